// File: common/cfg_port_pkg.sv
// constants and types for the two-wire configuration port
// Operation
// - slave only; master owns clock, START, STOP
// - data change while clock high is START/STOP
// - START begins a transfer from any state, including mid-transfer
// - one bit per pulse, sampled clock high
// - receiver acknowledges low on ninth pulse
// - works at standard and fast rates
// - address upper bits 1101, then direction bit
// - low address bits from two tri-level pins
// - address, command, then twelve data bytes
// - early STOP discards partial write
// - ack command and up to twelve write data bytes, commit on STOP
// - read returns id, reserved, twelve data
// - STOP ends readback, line released
// - store/load are two bytes, run after STOP
// - no acknowledges while store/load busy
// - load and store durations scale with oscillator
// - automatic load at power-up, about 3ms
// - registers read zero until power-up load
// - new contents applied to PLL after commit
// - bytes move lowest numbered first
// - first byte bits 95:88, last 7:0
package cfg_port_pkg;
	localparam int unsigned CLK_HZ         = 20_000_000;
	localparam int unsigned CFG_BITS       = 96;
	localparam int unsigned CFG_BYTES      = 12;
	localparam int unsigned READ_BYTES     = 14;
	localparam logic [3:0]  ADDR_FIXED     = 4'h d;
	localparam logic [7:0]  ID_BYTE_VAL    = 8'h 5a; // arbitrary value
	localparam logic [7:0]  RESV_BYTE_VAL  = 8'h 00;
	localparam logic [1:0]  CMD_WRITE      = 2'h 0;
	localparam logic [1:0]  CMD_STORE      = 2'h 1;
	localparam logic [1:0]  CMD_LOAD       = 2'h 2;
	localparam int unsigned POWERUP_LOAD_US = 3000;
	localparam int unsigned POWERUP_LOAD_CYC = POWERUP_LOAD_US * (CLK_HZ / 1_000_000);
	localparam int unsigned NV_LOAD_CYC    = 60_000;
	localparam int unsigned NV_STORE_CYC   = 1_200_000;
	localparam int unsigned TIMER_W        = 24;
	localparam logic [1:0]  TRI_LOW        = 2'h 0;
	localparam logic [1:0]  TRI_MID        = 2'h 1;
	localparam logic [1:0]  TRI_HIGH       = 2'h 2;
	typedef struct packed {
		logic scl;
		logic sda;
	} bus_lines_t;
	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} bus_events_t;
endpackage

// File: src/line_sync.sv
// two-flop synchroniser with edge and condition detection
`timescale 1ns/1ns
module line_sync (
	input  wire logic                     mclk,
	input  wire logic                     rst,
	input  wire logic                     clk_en,
	input  wire cfg_port_pkg::bus_lines_t raw,
	output cfg_port_pkg::bus_lines_t      lines,
	output cfg_port_pkg::bus_events_t     ev
);
	import cfg_port_pkg::*;
	bus_lines_t s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

	always_comb begin
		s1_d = s1_q;
		s2_d = s2_q;
		s3_d = s3_q;
		if (clk_en) begin
			s1_d = raw;
			s2_d = s1_q;
			s3_d = s2_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	assign lines    = s2_q;
	always_comb begin
		ev.rise  = s2_q.scl & ~s3_q.scl;
		ev.fall  = ~s2_q.scl & s3_q.scl;
		ev.start = s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
		ev.stop  = s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;
	end
endmodule

// File: src/addr_decode.sv
// tri-level pin pair to low address bits
`timescale 1ns/1ns
module addr_decode (
	input  wire logic [1:0] pin_high,
	input  wire logic [1:0] pin_low,
	output logic      [2:0] low_bits
);
	import cfg_port_pkg::*;
	always_comb begin
		low_bits = 3'h 0;
		unique case ({pin_high, pin_low})
			{TRI_LOW,  TRI_LOW}:  low_bits = 3'h 0;
			{TRI_LOW,  TRI_MID}:  low_bits = 3'h 1;
			{TRI_LOW,  TRI_HIGH}: low_bits = 3'h 2;
			{TRI_MID,  TRI_LOW}:  low_bits = 3'h 3;
			{TRI_MID,  TRI_MID}:  low_bits = 3'h 4;
			{TRI_MID,  TRI_HIGH}: low_bits = 3'h 5;
			{TRI_HIGH, TRI_LOW}:  low_bits = 3'h 6;
			{TRI_HIGH, TRI_MID}:  low_bits = 3'h 7;
			{TRI_HIGH, TRI_HIGH}: low_bits = 3'h 6;
			default:              low_bits = 3'h 0;
		endcase
	end
endmodule

// File: src/cfg_port.sv
// two-wire slave holding the 96-bit configuration and its nonvolatile copy
`timescale 1ns/1ns
module cfg_port #(
	parameter int unsigned POWERUP_CYC = cfg_port_pkg::POWERUP_LOAD_CYC,
	parameter int unsigned LOAD_CYC    = cfg_port_pkg::NV_LOAD_CYC,
	parameter int unsigned STORE_CYC   = cfg_port_pkg::NV_STORE_CYC
) (
	input  wire logic                        mclk,
	input  wire logic                        rst,
	input  wire logic                        clk_en,
	input  wire logic                        scl_i,
	input  wire logic                        sda_i,
	output logic                             sda_o,
	output logic                             sda_oe,
	input  wire logic [1:0]                  addr_select_pin_high,
	input  wire logic [1:0]                  addr_select_pin_low,
	input  wire logic                        power_down_n,
	output logic [cfg_port_pkg::CFG_BITS-1:0] cfg_q,
	output logic                             cfg_apply,
	output logic                             nv_busy,
	output logic                             config_write_cmd,
	output logic                             config_read_cmd,
	output logic                             nv_store_cmd,
	output logic                             nv_load_cmd
);
	import cfg_port_pkg::*;

	typedef enum logic [6:0] {
		S_IDLE  = 7'b000_0001,
		S_ADDR  = 7'b000_0010,
		S_AACK  = 7'b000_0100,
		S_RX    = 7'b000_1000,
		S_RACK  = 7'b001_0000,
		S_TX    = 7'b010_0000,
		S_TACK  = 7'b100_0000
	} st_t;

	bus_lines_t  lines;
	bus_events_t ev;
	logic [2:0]  low_bits;
	logic [4:0]  strap_s1_q, strap_s1_d, strap_s2_q, strap_s2_d;
	line_sync u_sync (
		.mclk   (mclk),
		.rst    (rst),
		.clk_en (clk_en),
		.raw    ({scl_i, sda_i}),
		.lines  (lines),
		.ev     (ev)
	);

	addr_decode u_dec (
		.pin_high (strap_s2_q[3:2]),
		.pin_low  (strap_s2_q[1:0]),
		.low_bits (low_bits)
	);
	st_t                 st_q, st_d;
	logic [7:0]          sh_q, sh_d;
	logic [3:0]          bit_q, bit_d;
	logic [3:0]          byte_q, byte_d;
	logic                rd_q, rd_d;
	logic [1:0]          cmd_q, cmd_d;
	logic                drive_q, drive_d;
	logic                out_q, out_d;
	logic [CFG_BITS-1:0] buf_q, buf_d;
	logic [CFG_BITS-1:0] cfg_d;
	logic [CFG_BITS-1:0] nv_q, nv_d;
	logic                apply_d;
	logic [TIMER_W-1:0]  tmr_q, tmr_d;
	logic                busy_q, busy_d;
	logic                pend_q, pend_d;
	logic [1:0]          op_q, op_d;
	logic                boot_q, boot_d;
	logic                wr_q, rdc_q, stc_q, ldc_q;
	logic                wr_d, rdc_d, stc_d, ldc_d;
	logic [7:0]          tx_byte;
	logic                addr_ok;

	assign addr_ok = (sh_q[7:4] == ADDR_FIXED) && (sh_q[3:1] == low_bits);
	always_comb begin
		tx_byte = RESV_BYTE_VAL;
		if (byte_q == 4'h 0) begin
			tx_byte = ID_BYTE_VAL;
		end else if (byte_q == 4'h 1) begin
			tx_byte = RESV_BYTE_VAL;
		end else if (byte_q < 4'(READ_BYTES)) begin
			tx_byte = cfg_q[CFG_BITS-1-8*(byte_q-4'h 2) -: 8];
		end
	end
	always_comb begin
		st_d    = st_q;
		sh_d    = sh_q;
		bit_d   = bit_q;
		byte_d  = byte_q;
		rd_d    = rd_q;
		cmd_d   = cmd_q;
		drive_d = drive_q;
		out_d   = out_q;
		buf_d   = buf_q;
		cfg_d   = cfg_q;
		nv_d    = nv_q;
		apply_d = 1'b0;
		tmr_d   = tmr_q;
		busy_d  = busy_q;
		pend_d  = pend_q;
		op_d    = op_q;
		boot_d  = boot_q;
		wr_d    = 1'b0;
		rdc_d   = 1'b0;
		stc_d   = 1'b0;
		ldc_d   = 1'b0;
		strap_s1_d = strap_s1_q;
		strap_s2_d = strap_s2_q;
		if (clk_en) begin
			strap_s1_d = {power_down_n, addr_select_pin_high, addr_select_pin_low};
			strap_s2_d = strap_s1_q;
			// nonvolatile sequencer
			if (boot_q && strap_s2_q[4]) begin
				boot_d = 1'b0;
				busy_d = 1'b1;
				op_d   = CMD_LOAD;
				tmr_d  = TIMER_W'(POWERUP_CYC);
			end else if (busy_q) begin
				if (tmr_q <= TIMER_W'(1)) begin
					busy_d = 1'b0;
					if (op_q == CMD_LOAD) begin
						cfg_d   = nv_q;
						apply_d = 1'b1;
					end else begin
						nv_d = cfg_q;
					end
				end else begin
					tmr_d = tmr_q - TIMER_W'(1);
				end
			end
			if (ev.start) begin
				st_d    = S_ADDR;
				bit_d   = 4'h 0;
				byte_d  = 4'h 0;
				drive_d = 1'b0;
				pend_d  = 1'b0;
			end else if (ev.stop) begin
				st_d    = S_IDLE;
				drive_d = 1'b0;
				if (pend_q && !rd_q) begin
					if (cmd_q == CMD_WRITE && byte_q == 4'(CFG_BYTES) + 4'h 1) begin
						cfg_d   = buf_q;
						apply_d = 1'b1;
					end else if ((cmd_q == CMD_STORE || cmd_q == CMD_LOAD) &&
						byte_q == 4'h 1) begin
						busy_d = 1'b1;
						op_d   = cmd_q;
						tmr_d  = (cmd_q == CMD_STORE) ? TIMER_W'(STORE_CYC) : TIMER_W'(LOAD_CYC);
					end
				end
				pend_d = 1'b0;
			end else begin
				unique case (st_q)
					S_IDLE: begin
					end
					S_ADDR, S_RX: begin
						if (ev.rise) begin
							sh_d  = {sh_q[6:0], lines.sda};
							bit_d = bit_q + 4'h 1;
						end else if (ev.fall && bit_q == 4'h 8) begin
							bit_d = 4'h 0;
							if (st_q == S_ADDR) begin
								if (addr_ok && !busy_q && !boot_q) begin
									drive_d = 1'b1;
									out_d   = 1'b0;
									rd_d    = sh_q[0];
									pend_d  = 1'b1;
									st_d    = S_AACK;
									if (sh_q[0]) begin
										rdc_d = 1'b1;
									end
								end else begin
									st_d = S_IDLE;
								end
							end else begin
								if (byte_q == 4'h 0) begin
									cmd_d = sh_q[1:0];
									wr_d  = (sh_q[1:0] == CMD_WRITE);
									stc_d = (sh_q[1:0] == CMD_STORE);
									ldc_d = (sh_q[1:0] == CMD_LOAD);
									drive_d = 1'b1;
									out_d   = 1'b0;
									st_d    = S_RACK;
								end else if (cmd_q == CMD_WRITE &&
									byte_q <= 4'(CFG_BYTES)) begin
									buf_d[CFG_BITS-1-8*(byte_q-4'h 1) -: 8] = sh_q;
									drive_d = 1'b1;
									out_d   = 1'b0;
									st_d    = S_RACK;
								end else begin
									st_d = S_IDLE;
								end
								byte_d = byte_q + 4'h 1;
							end
						end
					end
					S_AACK, S_RACK: begin
						if (ev.fall) begin
							if (st_q == S_AACK && rd_q) begin
								st_d    = S_TX;
								drive_d = 1'b1;
								out_d   = tx_byte[7];
								sh_d    = {tx_byte[6:0], 1'b0};
								bit_d   = 4'h 1;
							end else begin
								drive_d = 1'b0;
								st_d    = S_RX;
								bit_d   = 4'h 0;
							end
						end
					end
					S_TX: begin
						if (ev.fall) begin
							if (bit_q == 4'h 8) begin
								drive_d = 1'b0;
								st_d    = S_TACK;
								byte_d  = byte_q + 4'h 1;
							end else begin
								out_d = sh_q[7];
								sh_d  = {sh_q[6:0], 1'b0};
								bit_d = bit_q + 4'h 1;
							end
						end
					end
					S_TACK: begin
						if (ev.rise) begin
							rd_d = ~lines.sda;
						end else if (ev.fall) begin
							if (rd_q && byte_q < 4'(READ_BYTES)) begin
								st_d    = S_TX;
								drive_d = 1'b1;
								out_d   = tx_byte[7];
								sh_d    = {tx_byte[6:0], 1'b0};
								bit_d   = 4'h 1;
							end else begin
								st_d = S_IDLE;
							end
							rd_d = 1'b1;
						end
					end
					default: st_d = S_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q    <= S_IDLE;
			sh_q    <= 8'h 00;
			bit_q   <= 4'h 0;
			byte_q  <= 4'h 0;
			rd_q    <= 1'b0;
			cmd_q   <= 2'h 0;
			drive_q <= 1'b0;
			out_q   <= 1'b1;
			buf_q   <= '0;
			cfg_q   <= '0;
			nv_q    <= '0;
			cfg_apply <= 1'b0;
			tmr_q   <= '0;
			busy_q  <= 1'b0;
			pend_q  <= 1'b0;
			op_q    <= 2'h 0;
			boot_q  <= 1'b1;
			strap_s1_q <= '0;
			strap_s2_q <= '0;
			wr_q    <= 1'b0;
			rdc_q   <= 1'b0;
			stc_q   <= 1'b0;
			ldc_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			sh_q    <= sh_d;
			bit_q   <= bit_d;
			byte_q  <= byte_d;
			rd_q    <= rd_d;
			cmd_q   <= cmd_d;
			drive_q <= drive_d;
			out_q   <= out_d;
			buf_q   <= buf_d;
			cfg_q   <= cfg_d;
			nv_q    <= nv_d;
			cfg_apply <= apply_d;
			tmr_q   <= tmr_d;
			busy_q  <= busy_d;
			pend_q  <= pend_d;
			op_q    <= op_d;
			boot_q  <= boot_d;
			strap_s1_q <= strap_s1_d;
			strap_s2_q <= strap_s2_d;
			wr_q    <= wr_d;
			rdc_q   <= rdc_d;
			stc_q   <= stc_d;
			ldc_q   <= ldc_d;
		end
	end
	assign sda_oe           = drive_q & ~out_q;
	assign sda_o            = 1'b0;
	assign nv_busy          = busy_q | boot_q;
	assign config_write_cmd = wr_q;
	assign config_read_cmd  = rdc_q;
	assign nv_store_cmd     = stc_q;
	assign nv_load_cmd      = ldc_q;
	sequence stop_seen_s;
		ev.stop && clk_en;
	endsequence
	busy_noack_a: assert property (@(posedge mclk) disable iff (rst)
		(busy_q || boot_q) && st_q == S_ADDR |=> st_q != S_AACK)
		else $error("address acked while busy");
	stop_release_a: assert property (@(posedge mclk) disable iff (rst)
		stop_seen_s |=> !sda_oe && st_q == S_IDLE)
		else $error("line held after stop");
	partial_keep_a: assert property (@(posedge mclk) disable iff (rst)
		stop_seen_s and (byte_q != 4'(CFG_BYTES) + 4'h 1) and !busy_q |=> $stable(cfg_q))
		else $error("partial write changed config");
	commit_apply_a: assert property (@(posedge mclk) disable iff (rst)
		$changed(cfg_q) |-> cfg_apply)
		else $error("config changed without apply");
	boot_zero_a: assert property (@(posedge mclk) disable iff (rst)
		boot_q |-> cfg_q == '0)
		else $error("config nonzero before boot load");
	ack_low_a: assert property (@(posedge mclk) disable iff (rst)
		(st_q == S_AACK || st_q == S_RACK) && drive_q |-> sda_oe)
		else $error("ack not driven low");
	mismatch_drop_a: assert property (@(posedge mclk) disable iff (rst)
		st_q == S_ADDR && clk_en && ev.fall && bit_q == 4'h 8 && !addr_ok
		&& !ev.start && !ev.stop |=> st_q == S_IDLE && !sda_oe)
		else $error("mismatched address answered");
	load_timer_a: assert property (@(posedge mclk) disable iff (rst)
		busy_q && clk_en && tmr_q > TIMER_W'(1) |=> busy_q)
		else $error("nv operation ended early");
endmodule

// File: tb/i2c_master_model.sv
// two-wire bus master model driving the configuration port
`timescale 1ns/1ns
module i2c_master_model (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// data moves only while clock low, one bit per pulse
	task automatic put_bit(input logic b);
		#60 sda_low = ~b;
		#210 scl = 1'b1;
		#130 scl = 1'b0;
	endtask
	task automatic get_bit(output logic b);
		#60 sda_low = 1'b0;
		#210 scl = 1'b1;
		#120 b = sda;
		#10 scl = 1'b0;
	endtask
	// start from idle bus
	task automatic start();
		#205 sda_low = 1'b1;
		#200 scl = 1'b0;
	endtask
	task automatic stop();
		#60 sda_low = 1'b1;
		#210 scl = 1'b1;
		#200 sda_low = 1'b0;
		#425;
	endtask
	// ninth pulse carries the acknowledge
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(b);
		ack = ~b;
	endtask
	task automatic rd_byte(input logic ack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(~ack);
	endtask
endmodule

// File: tb/cfg_port_tb.sv
// self-checking bench for the two-wire configuration port
`timescale 1ns/1ns
module cfg_port_tb;
	import cfg_port_pkg::*;
	localparam logic [6:0] BASE = {ADDR_FIXED, 3'h0};
	logic        mclk, rst, power_down_n;
	logic [1:0]  pin_hi, pin_lo;
	wire         scl, m_low, sda_o, sda_oe, cfg_apply, nv_busy;
	wire  [3:0]  cmd;
	wire  [95:0] cfg_q;
	int          error_cnt, checks_done, n_apply, n_cmd[4];
	wire         sda = (sda_oe ? sda_o : 1'b1) & ~m_low;

	cfg_port #(.POWERUP_CYC(300), .LOAD_CYC(200), .STORE_CYC(400)) u_dut (
		.mclk(mclk), .rst(rst), .clk_en(1'b1), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .addr_select_pin_high(pin_hi),
		.addr_select_pin_low(pin_lo), .power_down_n(power_down_n), .cfg_q(cfg_q),
		.cfg_apply(cfg_apply), .nv_busy(nv_busy), .config_write_cmd(cmd[0]),
		.nv_store_cmd(cmd[1]), .nv_load_cmd(cmd[2]), .config_read_cmd(cmd[3]));
	i2c_master_model u_mst (.scl(scl), .sda_low(m_low), .sda(sda));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	always @(negedge mclk) begin
		n_apply += int'(cfg_apply === 1'b1);
		for (int i = 0; i < 4; i++) n_cmd[i] += int'(cmd[i] === 1'b1);
	end

	task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic clr();
		n_apply = 0;
		n_cmd = '{0, 0, 0, 0};
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 2000 && nv_busy !== 1'b0; i++) cyc(1);
		if (i == 2000) begin
			error_cnt++;
			$display("[FAIL] nv_busy expected 0 seen %b", nv_busy);
			wrap_up();
		end
	endtask
	task automatic probe(input logic [7:0] a, output logic ack);
		u_mst.start();
		u_mst.wr_byte(a, ack);
		u_mst.stop();
	endtask
	// address, command, payload, stop
	task automatic send(input logic [1:0] op, input int nb, input logic [95:0] v,
		output int acks);
		logic        a;
		logic [95:0] old;
		old = cfg_q;
		acks = 0;
		u_mst.start();
		u_mst.wr_byte({BASE, 1'b0}, a);
		acks += int'(a === 1'b1);
		u_mst.wr_byte({6'h2a, op}, a);
		acks += int'(a === 1'b1);
		for (int k = 0; k < nb; k++) begin
			u_mst.wr_byte(v[95-8*k -: 8], a);
			acks += int'(a === 1'b1);
		end
		chk("held before stop", old, cfg_q);
		u_mst.stop();
		cyc(10);
	endtask

	task automatic t_boot();
		logic a;
		chk("busy at boot", 1'b1, nv_busy);
		chk("cfg at boot", '0, cfg_q);
		probe({BASE, 1'b0}, a);
		chk("ack during boot", 1'b0, a);
		wait_idle();
		chk("cfg after boot", '0, cfg_q);
		chk("boot apply", 1, n_apply);
		probe({BASE, 1'b0}, a);
		chk("ack after boot", 1'b1, a);
		$display("test boot done");
	endtask
	task automatic t_write(input logic [95:0] v);
		int acks;
		clr();
		send(CMD_WRITE, 12, v, acks);
		chk("write acks", 14, acks);
		chk("write cfg", v, cfg_q);
		chk("write apply", 1, n_apply);
		chk("write cmd", 1, n_cmd[0]);
		$display("test write done");
	endtask
	task automatic t_partial(input logic [95:0] v, input logic [95:0] old);
		int acks;
		clr();
		send(CMD_WRITE, 5, v, acks);
		chk("partial acks", 7, acks);
		chk("partial cfg", old, cfg_q);
		send(2'h3, 0, v, acks);
		chk("code 11 acks", 2, acks);
		chk("code 11 cfg", old, cfg_q);
		chk("no apply", 0, n_apply + n_cmd[1] + n_cmd[2]);
		$display("test partial done");
	endtask
	task automatic t_read(input logic [95:0] v, input int n);
		logic         a;
		logic [7:0]   d;
		logic [111:0] exp;
		exp = {ID_BYTE_VAL, RESV_BYTE_VAL, v};
		clr();
		u_mst.start();
		u_mst.wr_byte({BASE, 1'b1}, a);
		chk("read addr ack", 1'b1, a);
		for (int k = 0; k < n; k++) begin
			u_mst.rd_byte(k < n - 1, d);
			chk("read byte", exp[111-8*k -: 8], d);
		end
		u_mst.stop();
		cyc(10);
		chk("line released", 1'b0, sda_oe);
		chk("read cmd", 1, n_cmd[3]);
		$display("test read done");
	endtask
	task automatic t_nv(input logic [95:0] v, input logic [95:0] w);
		int   acks;
		logic a;
		t_write(v);
		send(CMD_STORE, 0, w, acks);
		chk("store acks", 2, acks);
		chk("store cmd", 1, n_cmd[1]);
		chk("store busy", 1'b1, nv_busy);
		probe({BASE, 1'b0}, a);
		chk("ack while busy", 1'b0, a);
		wait_idle();
		t_write(w);
		send(CMD_LOAD, 0, w, acks);
		chk("load busy", 1'b1, nv_busy);
		wait_idle();
		chk("load cfg", v, cfg_q);
		chk("load cmd apply", 2, n_cmd[2] + n_apply - 1);
		$display("test nv done");
	endtask
	task automatic t_addr();
		logic [2:0] tbl [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h6};
		logic       a;
		for (int p = 0; p < 9; p++) begin
			@(posedge mclk);
			pin_hi <= 2'(p / 3);
			pin_lo <= 2'(p % 3);
			cyc(4);
			probe({ADDR_FIXED, tbl[p], 1'b0}, a);
			chk("pin address", 1'b1, a);
			probe({ADDR_FIXED, tbl[p] ^ 3'h1, 1'b0}, a);
			chk("wrong low bits", 1'b0, a);
		end
		probe({4'hc, tbl[8], 1'b0}, a);
		chk("wrong upper bits", 1'b0, a);
		$display("test address done");
	endtask

	initial begin
		rst <= 1'b1;
		power_down_n <= 1'b1;
		pin_hi <= 2'h0;
		pin_lo <= 2'h0;
		error_cnt = 0;
		checks_done = 0;
		clr();
		cyc(6);
		rst <= 1'b0;
		cyc(2);
		t_boot();
		t_write(96'h0123_4567_89ab_cdef_fedc_ba98);
		t_partial(96'h5555_aaaa_0f0f_f0f0_3c3c_c3c3, 96'h0123_4567_89ab_cdef_fedc_ba98);
		t_read(96'h0123_4567_89ab_cdef_fedc_ba98, 14);
		t_read(96'h0123_4567_89ab_cdef_fedc_ba98, 3);
		t_nv(96'h5555_aaaa_0f0f_f0f0_3c3c_c3c3, 96'h0123_4567_89ab_cdef_fedc_ba98);
		t_addr();
		wrap_up();
	end
endmodule
